/* design/ppec_pkg.sv */
// Constants for the bus parity, error and reset control block.
// Assumes one 200 MHz clock and an asynchronous active-low reset.
package ppec_pkg;
	// --------------------------------------------------------------
	// Register offsets
	// --------------------------------------------------------------
	localparam logic [7:0] PPEC_OFS_CTRL = 8'h00;
	localparam logic [7:0] PPEC_OFS_INT_STATUS = 8'h04;
	localparam logic [7:0] PPEC_OFS_INT_MASK = 8'h08;
	localparam logic [7:0] PPEC_OFS_CFG_CS = 8'h0C;
	localparam logic [7:0] PPEC_OFS_STATE = 8'h10;
	// --------------------------------------------------------------
	// Field positions
	// --------------------------------------------------------------
	localparam int PPEC_CTRL_SWRST = 0;
	localparam int PPEC_CTRL_ROM_CS = 1;
	localparam int PPEC_CTRL_BOOT_CE = 2;
	localparam int PPEC_IS_SYS_ERR = 13;
	localparam int PPEC_IS_APE = 14;
	localparam int PPEC_IS_STOP = 15;
	localparam int PPEC_CS_SERR_EN = 8;
	localparam int PPEC_CS_DPR = 24;
	localparam int PPEC_CS_SSE = 30;
	localparam int PPEC_CS_DPE = 31;
	// --------------------------------------------------------------
	// Reset values and masks
	// --------------------------------------------------------------
	localparam logic [31:0] PPEC_RST_CTRL = 32'h0000_0000;
	localparam logic [31:0] PPEC_RST_MASK = 32'h0000_0000;
	localparam logic [31:0] PPEC_RST_CFG = 32'h0000_0000;
	localparam logic [31:0] PPEC_IS_W1C = 32'h0000_E000;
	localparam logic [31:0] PPEC_CS_W1C = 32'hC100_0000;
	// --------------------------------------------------------------
	// Timing
	// --------------------------------------------------------------
	localparam int PPEC_SERR_DELAY = 2;
	localparam int PPEC_RST_MIN_EDGES = 10;
	// --------------------------------------------------------------
	// Target stop outcomes
	// --------------------------------------------------------------
	typedef enum logic [1:0] {
		PPEC_STOP_NONE,
		PPEC_STOP_DISCONNECT,
		PPEC_STOP_RETRY,
		PPEC_STOP_ABORT
	} ppec_stop_t;
endpackage : ppec_pkg

/* design/ppec_parity.sv */
// Even parity over the 32 address/data and 4 command/enable lines.
// Assumes inputs are synchronous to i_mclk; result registered one cycle later.
`timescale 1ns/1ps
module ppec_parity
	import ppec_pkg::*;
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_arst_n,
	// Lines covered
	input wire logic [31:0] i_ad,
	input wire logic [3:0] i_cbe_n,
	// Parity of the previous cycle
	output logic o_par
);
	// All lines count, meaningful or not, so the bit follows the bus blindly
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_par <= 1'b0;
		end else begin
			o_par <= ^{i_ad, i_cbe_n};
		end
	end
endmodule : ppec_parity

/* design/ppec_core.sv */
// Bus parity, error report, mode strap and reset control.
// Assumes the bus pins are synchronous to i_mclk and a simple register port.
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module ppec_core
	import ppec_pkg::*;
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_arst_n,
	// Register port
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// Bus lines observed
	input wire logic [31:0] i_ad,
	input wire logic [3:0] i_cbe_n,
	input wire logic i_par,
	input wire logic i_addr_phase,
	input wire logic i_data_phase,
	input wire logic i_master,
	input wire logic i_is_read,
	input wire logic i_burst_end,
	input wire logic i_stop_n,
	input wire logic i_trdy_n,
	input wire logic i_devsel_n,
	// Master engine handshake
	input wire logic i_need_bus,
	input wire logic i_rom_busy,
	output logic o_halted,
	output ppec_stop_t o_stop_kind,
	// Parity pin
	output logic o_par,
	output logic o_par_oe,
	// Error pins, open drain
	output logic o_perr_n,
	output logic o_perr_oe,
	output logic o_serr_oe,
	// Request and chip selects
	output logic o_req_n,
	output logic o_req_oe,
	output logic o_srom_cs,
	output logic o_srom_cs_oe,
	// Mode strap / boot enable pin
	input wire logic i_mode_strap,
	output logic o_boot_rom_chip_enable_n,
	output logic o_boot_oe,
	output logic o_mode,
	// Interrupt, open drain
	output logic o_int_oe
);
	// --------------------------------------------------------------
	// State
	// --------------------------------------------------------------
	typedef enum logic [1:0] {
		PPEC_RUN,
		PPEC_FINISH,
		PPEC_HALT
	} ppec_run_t;

	ppec_run_t run_state;
	logic [31:0] ctrl;
	logic [31:0] int_status;
	logic [31:0] int_mask;
	logic [31:0] cfg_cs;
	logic mode;
	logic strap_pending;
	logic par_phase_q;
	logic par_master_q;
	logic par_read_q;
	logic par_addr_q;
	logic [31:0] ad_q;
	logic [3:0] cbe_q;
	logic data_perr;
	logic addr_perr;
	logic master_perr;
	logic serr_pipe;
	logic perr_hold;
	logic drive_q;
	logic bus_live;
	logic stop_ev;
	logic wr_ctrl;
	logic wr_is;
	logic wr_mask;
	logic wr_cs;
	logic next_swrst;

	// Decode one register offset
	function automatic logic ppec_hit(input logic [7:0] a, input logic [7:0] ofs);
		ppec_hit = (a == ofs);
	endfunction : ppec_hit

	assign wr_ctrl = i_wr && ppec_hit(i_addr, PPEC_OFS_CTRL);
	assign wr_is = i_wr && ppec_hit(i_addr, PPEC_OFS_INT_STATUS);
	assign wr_mask = i_wr && ppec_hit(i_addr, PPEC_OFS_INT_MASK);
	assign wr_cs = i_wr && ppec_hit(i_addr, PPEC_OFS_CFG_CS);
	assign next_swrst = wr_ctrl && i_wdata[PPEC_CTRL_SWRST];

	// --------------------------------------------------------------
	// Parity generation
	// --------------------------------------------------------------
	ppec_parity u_parity (
		.i_mclk(i_mclk),
		.i_arst_n(i_arst_n),
		.i_ad(i_ad),
		.i_cbe_n(i_cbe_n),
		.o_par(o_par)
	);

	// Parity pin driven the cycle after a phase we drive; floats in reset
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			drive_q <= 1'b0;
		end else begin
			// Master drives address; data goes the way of the transfer
			drive_q <= (i_addr_phase && i_master)
				|| (i_data_phase && (i_master != i_is_read));
		end
	end
	assign o_par_oe = drive_q;

	// --------------------------------------------------------------
	// Parity check: register phase, compare with par arriving next cycle
	// --------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ad_q <= 32'h0000_0000;
			cbe_q <= 4'h0;
			par_phase_q <= 1'b0;
			par_addr_q <= 1'b0;
			par_master_q <= 1'b0;
			par_read_q <= 1'b0;
		end else begin
			ad_q <= i_ad;
			cbe_q <= i_cbe_n;
			par_phase_q <= i_data_phase;
			par_addr_q <= i_addr_phase && !i_master;
			par_master_q <= i_master;
			par_read_q <= i_is_read;
		end
	end

	// Only master reads and target writes check data parity
	assign data_perr = par_phase_q && (par_master_q == par_read_q)
		&& ((^{ad_q, cbe_q}) != i_par);
	assign master_perr = data_perr && par_master_q;
	assign addr_perr = par_addr_q && ((^{ad_q, cbe_q}) != i_par);

	// Data parity error pin pulses for one cycle
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			perr_hold <= 1'b0;
		end else begin
			perr_hold <= data_perr;
		end
	end
	assign o_perr_n = !perr_hold;
	assign o_perr_oe = perr_hold;

	// System error: address in cycle 0, check in 1, pin in 2
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			serr_pipe <= 1'b0;
		end else begin
			serr_pipe <= addr_perr && cfg_cs[PPEC_CS_SERR_EN];
		end
	end
	assign o_serr_oe = serr_pipe;

	// --------------------------------------------------------------
	// Run state: finish burst then halt until system error cleared
	// --------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			run_state <= PPEC_RUN;
		end else if (next_swrst) begin
			run_state <= PPEC_RUN;
		end else begin
			case (run_state)
				PPEC_RUN: begin
					if (master_perr) begin
						run_state <= i_burst_end ? PPEC_HALT : PPEC_FINISH;
					end
				end
				PPEC_FINISH: begin
					if (i_burst_end) begin
						run_state <= PPEC_HALT;
					end
				end
				PPEC_HALT: begin
					if (!int_status[PPEC_IS_SYS_ERR]) begin
						run_state <= PPEC_RUN;
					end
				end
				default: begin
					run_state <= PPEC_RUN;
				end
			endcase
		end
	end
	assign o_halted = (run_state == PPEC_HALT);

	// --------------------------------------------------------------
	// Bus request
	// --------------------------------------------------------------
	assign o_req_n = !(i_need_bus && (run_state == PPEC_RUN));
	// Request and serial ROM select pins float through reset, come alive on the first edge after it
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			bus_live <= 1'b0;
		end else begin
			bus_live <= 1'b1;
		end
	end
	assign o_req_oe = bus_live;

	// Target stop classification
	always_comb begin
		o_stop_kind = PPEC_STOP_NONE;
		if (i_master && !i_stop_n) begin
			if (i_devsel_n) begin
				o_stop_kind = PPEC_STOP_ABORT;
			end else if (i_trdy_n) begin
				o_stop_kind = PPEC_STOP_RETRY;
			end else begin
				o_stop_kind = PPEC_STOP_DISCONNECT;
			end
		end
	end
	assign stop_ev = (o_stop_kind == PPEC_STOP_ABORT);

	// --------------------------------------------------------------
	// Registers
	// --------------------------------------------------------------
	// Control register; soft reset bit self-clears
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ctrl <= PPEC_RST_CTRL;
		end else if (wr_ctrl) begin
			ctrl <= {i_wdata[31:1], 1'b0};
		end
	end

	// Status bits: the set wins over a write-one clear
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			int_status <= 32'h0000_0000;
		end else begin
			int_status <= (int_status & ~(wr_is ? (i_wdata & PPEC_IS_W1C) : 32'h0))
				| ({31'h0, master_perr} << PPEC_IS_SYS_ERR)
				| ({31'h0, addr_perr} << PPEC_IS_APE)
				| ({31'h0, stop_ev} << PPEC_IS_STOP);
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			int_mask <= PPEC_RST_MASK;
		end else if (wr_mask) begin
			int_mask <= i_wdata & PPEC_IS_W1C;
		end
	end

	// Command/status: enable writable, error bits sticky and write-one clear
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cfg_cs <= PPEC_RST_CFG;
		end else begin
			if (wr_cs) begin
				cfg_cs[PPEC_CS_SERR_EN] <= i_wdata[PPEC_CS_SERR_EN];
			end
			cfg_cs[PPEC_CS_DPR] <= master_perr
				|| (cfg_cs[PPEC_CS_DPR] && !(wr_cs && i_wdata[PPEC_CS_DPR]));
			cfg_cs[PPEC_CS_DPE] <= master_perr
				|| (cfg_cs[PPEC_CS_DPE] && !(wr_cs && i_wdata[PPEC_CS_DPE]));
			cfg_cs[PPEC_CS_SSE] <= (addr_perr && cfg_cs[PPEC_CS_SERR_EN])
				|| (cfg_cs[PPEC_CS_SSE] && !(wr_cs && i_wdata[PPEC_CS_SSE]));
		end
	end

	assign o_int_oe = |(int_status & int_mask);

	// Read data one cycle after the strobe; unmapped reads zero
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_rdata <= 32'h0000_0000;
		end else if (i_rd) begin
			case (i_addr)
				PPEC_OFS_CTRL: o_rdata <= ctrl;
				PPEC_OFS_INT_STATUS: o_rdata <= int_status;
				PPEC_OFS_INT_MASK: o_rdata <= int_mask;
				PPEC_OFS_CFG_CS: o_rdata <= cfg_cs & (PPEC_CS_W1C | 32'h0000_0100);
				PPEC_OFS_STATE: o_rdata <= {30'h0, o_halted, mode};
				default: o_rdata <= 32'h0000_0000;
			endcase
		end else begin
			o_rdata <= 32'h0000_0000;
		end
	end

	// --------------------------------------------------------------
	// Mode strap: sampled the first cycle after any reset
	// --------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			strap_pending <= 1'b1;
			mode <= 1'b1;
		end else begin
			strap_pending <= next_swrst;
			if (strap_pending) begin
				mode <= i_mode_strap;
			end
		end
	end
	assign o_mode = mode;
	// Pin stays an input while the strap is being read
	assign o_boot_oe = mode && !strap_pending;
	assign o_boot_rom_chip_enable_n = !ctrl[PPEC_CTRL_BOOT_CE];
	assign o_srom_cs = i_rom_busy || ctrl[PPEC_CTRL_ROM_CS];
	assign o_srom_cs_oe = bus_live;

	// --------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------
	property p_serr_two;
		@(posedge i_mclk) disable iff (!i_arst_n)
		(i_addr_phase && !i_master && cfg_cs[PPEC_CS_SERR_EN]) ##1 (i_par != ^{ad_q, cbe_q})
			|-> ##1 o_serr_oe;
	endproperty
	a_serr_two: assert property (p_serr_two) else $error("serr late");

	property p_sse_set;
		@(posedge i_mclk) disable iff (!i_arst_n)
		o_serr_oe |-> cfg_cs[PPEC_CS_SSE];
	endproperty
	a_sse_set: assert property (p_sse_set) else $error("sse missing");

	property p_perr_pulse;
		@(posedge i_mclk) disable iff (!i_arst_n)
		data_perr |=> (o_perr_oe && !o_perr_n);
	endproperty
	a_perr_pulse: assert property (p_perr_pulse) else $error("perr missing");

	property p_master_status;
		@(posedge i_mclk) disable iff (!i_arst_n)
		master_perr |=> (int_status[PPEC_IS_SYS_ERR] && cfg_cs[PPEC_CS_DPE] && cfg_cs[PPEC_CS_DPR]);
	endproperty
	a_master_status: assert property (p_master_status) else $error("status missing");

	property p_halt_held;
		@(posedge i_mclk) disable iff (!i_arst_n)
		(o_halted && int_status[PPEC_IS_SYS_ERR] && !next_swrst) |=> o_halted;
	endproperty
	a_halt_held: assert property (p_halt_held) else $error("left halt early");

	property p_req;
		@(posedge i_mclk) disable iff (!i_arst_n)
		(i_need_bus && run_state == PPEC_RUN) |-> !o_req_n;
	endproperty
	a_req: assert property (p_req) else $error("no request");

	property p_sticky;
		@(posedge i_mclk) disable iff (!i_arst_n)
		(cfg_cs[PPEC_CS_DPE] && !wr_cs) |=> cfg_cs[PPEC_CS_DPE];
	endproperty
	a_sticky: assert property (p_sticky) else $error("dpe lost");

	property p_strap;
		@(posedge i_mclk) disable iff (!i_arst_n)
		(strap_pending && i_arst_n) |=> (mode == $past(i_mode_strap));
	endproperty
	a_strap: assert property (p_strap) else $error("strap not taken");

	property p_parity;
		@(posedge i_mclk) disable iff (!i_arst_n)
		i_arst_n |=> (o_par == ^{$past(i_ad), $past(i_cbe_n)});
	endproperty
	a_parity: assert property (p_parity) else $error("parity wrong");
endmodule : ppec_core

/* sim/ppec_bus_model.sv */
// Far-side bus agent: drives address/data phases, parity and stop replies.
// Assumes the bench calls its tasks in order, one transfer at a time.
`timescale 1ns/1ps
module ppec_bus_model
	import ppec_pkg::*;
(
	// Clock
	input wire logic i_mclk,
	// Bus lines toward the block
	output logic [31:0] o_ad,
	output logic [3:0] o_cbe_n,
	output logic o_par,
	output logic o_addr_phase,
	output logic o_data_phase,
	output logic o_master,
	output logic o_is_read,
	output logic o_burst_end,
	output logic o_stop_n,
	output logic o_trdy_n,
	output logic o_devsel_n
);
	// --------------------------------------------------------------
	// Idle levels: sustained lines rest high on their pull-ups
	// --------------------------------------------------------------
	initial begin
		o_ad = 32'h0000_0000;
		o_cbe_n = 4'hF;
		o_par = 1'b1;
		o_addr_phase = 1'b0;
		o_data_phase = 1'b0;
		o_master = 1'b0;
		o_is_read = 1'b0;
		o_burst_end = 1'b0;
		o_stop_n = 1'b1;
		o_trdy_n = 1'b1;
		o_devsel_n = 1'b1;
	end
	// One phase, then its parity in the next cycle; bad flips the parity
	task phase(input logic is_addr, input logic [31:0] ad, input logic [3:0] cbe,
		input logic bad, input logic mst, input logic rd);
		@(posedge i_mclk);
		o_ad <= ad;
		o_cbe_n <= cbe;
		o_addr_phase <= is_addr;
		o_data_phase <= !is_addr;
		o_master <= mst;
		o_is_read <= rd;
		@(posedge i_mclk);
		o_par <= (^{ad, cbe}) ^ bad;
		// Released lines take an odd-weight change so a late parity shows
		o_ad <= ~ad ^ 32'h0000_0001;
		o_cbe_n <= ~cbe;
		o_addr_phase <= 1'b0;
		o_data_phase <= 1'b0;
	endtask : phase
	// Stop reply: abort without device select, retry without target ready
	task stop(input ppec_stop_t kind);
		@(posedge i_mclk);
		o_master <= 1'b1;
		o_stop_n <= 1'b0;
		o_devsel_n <= (kind == PPEC_STOP_ABORT);
		o_trdy_n <= (kind != PPEC_STOP_DISCONNECT);
	endtask : stop
	// Release the stop reply
	task stop_end();
		@(posedge i_mclk);
		o_master <= 1'b0;
		o_stop_n <= 1'b1;
		o_devsel_n <= 1'b1;
		o_trdy_n <= 1'b1;
	endtask : stop_end
	// One-cycle end of burst
	task burst_end();
		@(posedge i_mclk);
		o_burst_end <= 1'b1;
		@(posedge i_mclk);
		o_burst_end <= 1'b0;
	endtask : burst_end
endmodule : ppec_bus_model

/* sim/ppec_core_tb.sv */
// Self-checking bench for the parity, error and reset control block.
// Assumes ppec_bus_model plays the far side; registers via the plain port.
`timescale 1ns/1ps
module ppec_core_tb
	import ppec_pkg::*;
;
	logic i_mclk, i_arst_n, i_wr, i_rd, i_need_bus, i_rom_busy, strap_low, i_mode_strap;
	logic [7:0] i_addr;
	logic [31:0] i_wdata, o_rdata, i_ad, rdv;
	logic [3:0] i_cbe_n;
	logic i_par, i_addr_phase, i_data_phase, i_master, i_is_read, i_burst_end;
	logic i_stop_n, i_trdy_n, i_devsel_n, o_halted, o_par, o_par_oe, o_perr_n, o_perr_oe;
	logic o_serr_oe, o_req_n, o_req_oe, o_srom_cs, o_srom_cs_oe, o_boot_ce_n, o_boot_oe;
	logic o_mode, o_int_oe;
	ppec_stop_t o_stop_kind;
	int err_total = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [31:0] pad [4] = '{32'h0000_0000, 32'hFFFF_FFFF, 32'h8000_0001, 32'h1234_5678};
	logic [3:0] pcb [4] = '{4'h0, 4'hF, 4'h6, 4'hA};
	// Strap pin wire: the block's drive wins, else tie-low or pull-up
	assign i_mode_strap = o_boot_oe ? o_boot_ce_n : !strap_low;
	ppec_core uut (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ad(i_ad), .i_cbe_n(i_cbe_n),
		.i_par(i_par), .i_addr_phase(i_addr_phase), .i_data_phase(i_data_phase),
		.i_master(i_master), .i_is_read(i_is_read), .i_burst_end(i_burst_end),
		.i_stop_n(i_stop_n), .i_trdy_n(i_trdy_n), .i_devsel_n(i_devsel_n),
		.i_need_bus(i_need_bus), .i_rom_busy(i_rom_busy), .o_halted(o_halted),
		.o_stop_kind(o_stop_kind), .o_par(o_par), .o_par_oe(o_par_oe), .o_perr_n(o_perr_n),
		.o_perr_oe(o_perr_oe), .o_serr_oe(o_serr_oe), .o_req_n(o_req_n), .o_req_oe(o_req_oe),
		.o_srom_cs(o_srom_cs), .o_srom_cs_oe(o_srom_cs_oe), .i_mode_strap(i_mode_strap),
		.o_boot_rom_chip_enable_n(o_boot_ce_n), .o_boot_oe(o_boot_oe), .o_mode(o_mode),
		.o_int_oe(o_int_oe));
	ppec_bus_model bus (.i_mclk(i_mclk), .o_ad(i_ad), .o_cbe_n(i_cbe_n), .o_par(i_par),
		.o_addr_phase(i_addr_phase), .o_data_phase(i_data_phase), .o_master(i_master),
		.o_is_read(i_is_read), .o_burst_end(i_burst_end), .o_stop_n(i_stop_n),
		.o_trdy_n(i_trdy_n), .o_devsel_n(i_devsel_n));
	// --------------------------------------------------------------
	// Clock and hang guard
	// --------------------------------------------------------------
	initial begin
		i_mclk = 1'b0;
		forever #2.5 i_mclk = !i_mclk;
	end
	// Whole run needs well under a thousand cycles
	always @(posedge i_mclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			err_total++;
			summarize();
		end
	end
	// --------------------------------------------------------------
	// Shared tasks
	// --------------------------------------------------------------
	task summarize();
		if (err_total == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr <= 1'b0;
		#1;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task rd(input logic [7:0] a);
		@(posedge i_mclk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 rdv = o_rdata;
	endtask : rd
	// Hardware reset, ten edges, with a look at the pins midway
	task hw_reset();
		@(posedge i_mclk);
		i_arst_n <= 1'b0;
		repeat (5) @(posedge i_mclk);
		#1 chk("oe_in_reset", {o_par_oe, o_perr_oe, o_serr_oe, o_boot_oe, o_int_oe, o_req_oe,
			o_srom_cs_oe}, 0);
		chk("req_n_in_reset", o_req_n, 1);
		repeat (5) @(posedge i_mclk);
		i_arst_n <= 1'b1;
		repeat (3) @(posedge i_mclk);
		#1;
	endtask : hw_reset
	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial begin
		i_arst_n = 1'b0;
		i_addr = 8'h00;
		i_wdata = 32'h0000_0000;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_need_bus = 1'b0;
		i_rom_busy = 1'b0;
		strap_low = 1'b0;
		hw_reset();
		chk("mode_open", {o_mode, o_boot_oe, o_req_oe}, 7);
		rd(PPEC_OFS_STATE);
		chk("state_mode", rdv & 32'h1, 1);
		rd(PPEC_OFS_CFG_CS);
		chk("cfg_reset", rdv, PPEC_RST_CFG);
		rd(PPEC_OFS_INT_MASK);
		chk("mask_reset", rdv, PPEC_RST_MASK);
		wr(8'h40, 32'hFFFF_FFFF);
		rd(8'h40);
		chk("unmapped", rdv, 0);
		wr(PPEC_OFS_CTRL, 32'h4);
		chk("boot_ce_on", o_boot_ce_n, 0);
		wr(PPEC_OFS_CTRL, 32'h0);
		chk("boot_ce_off", o_boot_ce_n, 1);
		// Parity over every line, address and data phases alike
		for (int i = 0; i < 4; i++) begin
			bus.phase(i[0], pad[i], pcb[i], 1'b0, 1'b0, 1'b0);
			#1 chk("par_out", o_par, ^{pad[i], pcb[i]});
		end
		// Address parity error: reported exactly two clocks on, only if enabled
		wr(PPEC_OFS_CFG_CS, 32'h100);
		bus.phase(1'b1, 32'hA5A5_0000, 4'h6, 1'b1, 1'b0, 1'b0);
		#1 chk("serr_c1", o_serr_oe, 0);
		@(posedge i_mclk);
		#1 chk("serr_c2", o_serr_oe, 1);
		rd(PPEC_OFS_CFG_CS);
		chk("cfg_sse", rdv, 32'h4000_0100);
		wr(PPEC_OFS_CFG_CS, 32'h4000_0000);
		bus.phase(1'b1, 32'h0000_5A5A, 4'h7, 1'b1, 1'b0, 1'b0);
		@(posedge i_mclk);
		#1 chk("serr_off", o_serr_oe, 0);
		rd(PPEC_OFS_CFG_CS);
		chk("cfg_clear", rdv, 0);
		wr(PPEC_OFS_INT_STATUS, PPEC_IS_W1C);
		// Data parity: master write is not checked, target write is
		bus.phase(1'b0, 32'h0F0F_0F0F, 4'h0, 1'b1, 1'b1, 1'b0);
		#1 chk("par_oe_mwr", o_par_oe, 1);
		@(posedge i_mclk);
		#1 chk("perr_mwr", o_perr_oe, 0);
		bus.phase(1'b0, 32'hF0F0_0000, 4'h3, 1'b1, 1'b0, 1'b0);
		@(posedge i_mclk);
		#1 chk("perr_twr", {o_perr_oe, o_perr_n}, 2);
		bus.phase(1'b0, 32'h0000_F0F0, 4'h0, 1'b1, 1'b1, 1'b1);
		@(posedge i_mclk);
		#1 chk("perr_mrd", {o_perr_oe, o_perr_n}, 2);
		chk("run_in_burst", o_halted, 0);
		bus.burst_end();
		#1 chk("halt_after_burst", o_halted, 1);
		repeat (20) @(posedge i_mclk);
		i_need_bus <= 1'b1;
		rd(PPEC_OFS_INT_STATUS);
		chk("sys_err_held", rdv & 32'h2000, 32'h2000);
		chk("still_halted", {o_halted, o_req_n}, 3);
		// Interrupt follows status bits whose mask bit enables them
		chk("int_masked", o_int_oe, 0);
		wr(PPEC_OFS_INT_MASK, 32'h2000);
		chk("int_on", o_int_oe, 1);
		wr(PPEC_OFS_INT_STATUS, 32'h2000);
		// Run state sees the cleared bit one edge after the write lands
		@(posedge i_mclk);
		#1 chk("resumed", {o_halted, o_int_oe, o_req_n}, 0);
		rd(PPEC_OFS_CFG_CS);
		chk("cfg_dpe", rdv & PPEC_CS_W1C, 32'h8100_0000);
		wr(PPEC_OFS_CFG_CS, PPEC_CS_W1C);
		rd(PPEC_OFS_CFG_CS);
		chk("cfg_w1c", rdv, 0);
		// Every target stop outcome
		for (int k = 1; k < 4; k++) begin
			bus.stop(ppec_stop_t'(k));
			#1 chk("stop_kind", o_stop_kind, k);
			bus.stop_end();
		end
		rd(PPEC_OFS_INT_STATUS);
		chk("stop_status", rdv & 32'h8000, 32'h8000);
		wr(PPEC_OFS_INT_STATUS, PPEC_IS_W1C);
		// Request and serial ROM select follow their causes
		@(posedge i_mclk);
		i_need_bus <= 1'b1;
		i_rom_busy <= 1'b1;
		#1 chk("req_on", {o_req_n, o_srom_cs}, 1);
		@(posedge i_mclk);
		i_need_bus <= 1'b0;
		i_rom_busy <= 1'b0;
		#1 chk("req_off", {o_req_n, o_srom_cs}, 2);
		// Strap tied low through a hardware reset, then open through soft reset
		strap_low = 1'b1;
		hw_reset();
		chk("mode_low", {o_mode, o_boot_oe}, 0);
		strap_low = 1'b0;
		wr(PPEC_OFS_CTRL, 32'h1);
		repeat (3) @(posedge i_mclk);
		#1 chk("mode_soft", o_mode, 1);
		summarize();
	end
endmodule : ppec_core_tb
